/* sic_indicator.sv */
`timescale 1ns/1ns
// What this block does
// - Operating lamp: solid blue normal, blinking waiting, dark fault.
// - Error lamp: solid red in fault, dark when normal.
// - Battery lamp: solid green normal link, blinking idle, dark battery fault.
// - Escape leaves current page or edit; enter confirms selection.
// - Up moves cursor up, or increments edited value by one.
// - Down moves cursor down, or decrements edited value by one.
// - Normal state: keys cycle power, daily-yield and battery pages.
// - Error state: fault page shown with the active error code.
// - Mode, periods, reserve apply only if charge minus new reserve at least 2%.
// - Charging starts when system time is inside the new charging period.
// - Holding pack button about 1-2 s activates unit and starts self test.
// - Self test: status flashes yellow at 0.1 s step, level lamps dark.
// - After self test, before inverter link: green flash 0.5 s step, levels dark.
// - Inverter link up: solid green status, level lamps show capacity.
// - Hold over 1 s while running: solid green, level lamps chase blue.
// - After release in shutdown, all pack lamps dark within 2.4 s.
// - Standby: green 1 s on, 4 s off, level lamps dark.
// - Charging or discharging: solid green, levels follow direction and charge.
// - Fault: solid red 10 minutes, then red 1 s on, 4 s off.
// - Warning: yellow 1 s on, 4 s off.
// - Charging: done quarters solid, current quarter flashes, rest dark; full all solid.
// - Discharging: lamp 1 flashes; lamps 2-4 flash at 25, 50, 75 percent.
// - Fault: level lamps show distinct flash pattern per fault class.
// - Hold over 20 s runs black start; 5-20 s selects inverter startup.
module sic_indicator #(
  parameter int unsigned TICK_CYCLES = sic_pkg::TICK_CYCLES
) (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire sic_pkg::sic_bus_req_t    bus_req,
  output logic [31:0]                   bus_rdata,
  input  wire logic                     pack_power_button,
  input  wire logic                     key_esc,
  input  wire logic                     key_up,
  input  wire logic                     key_down,
  input  wire logic                     key_enter,
  output sic_pkg::sic_inv_lamps_t       inv_lamps,
  output sic_pkg::sic_pack_lamps_t      pack_lamps,
  output sic_pkg::sic_page_t            screen_page,
  output logic [7:0]                    screen_error_code,
  output logic                          charge_request,
  output logic                          inverter_start
);
  import sic_pkg::*;

  typedef enum logic [2:0] {P_OFF, P_BLACK, P_SELFTEST, P_WAITCOMM, P_RUN, P_SHUTDOWN} sic_pack_state_t;

  localparam int NBTN = 5;  // 0 pack button, 1 esc, 2 up, 3 down, 4 enter

  logic [NBTN-1:0] pin_raw;
  logic [NBTN-1:0] sync1_q, sync2_q, samp_q, deb_q, press_q;
  logic [19:0]     pre_q;
  logic            tick;
  logic            soft_clr;
  logic [31:0]     ctrl_q, cfg_q, active_q;
  logic [6:0]      soc_q;
  logic [4:0]      hour_q;
  logic [7:0]      err_q;
  logic            cfg_valid_q, reject_q;
  logic [5:0]      ph_q;
  logic [7:0]      hold_q, st_q;
  logic [12:0]     flt_q;
  logic [1:0]      step_q;
  sic_pack_state_t pack_q;
  sic_page_t       page_q;
  logic            menu_q, edit_q;
  logic [1:0]      cursor_q;
  logic [7:0]      value_q;
  sic_inv_state_t  inv_st;
  sic_bat_state_t  bat_st;
  sic_run_mode_t   run_md;
  logic            fast_on, half_on, slow_on;
  sic_pack_lamps_t pack_d;
  sic_inv_lamps_t  inv_d;

  assign pin_raw  = {key_enter, key_down, key_up, key_esc, pack_power_button};
  assign inv_st   = sic_inv_state_t'(ctrl_q[CTRL_INV_LSB +: 2]);
  assign bat_st   = sic_bat_state_t'(ctrl_q[CTRL_BAT_LSB +: 2]);
  assign run_md   = sic_run_mode_t'(ctrl_q[CTRL_RUN_LSB +: 3]);
  assign soft_clr = bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[CTRL_CLEAR];

  // Charging lamps: finished quarters solid, current one flashing
  function automatic logic [3:0] chg_solid(input logic [6:0] soc);
    if (soc >= 7'd100) chg_solid = 4'hf;
    else if (soc >= 7'd75) chg_solid = 4'h7;
    else if (soc >= 7'd50) chg_solid = 4'h3;
    else if (soc >= 7'd25) chg_solid = 4'h1;
    else chg_solid = 4'h0;
  endfunction

  // Discharging lamps: every lamp up to the reached threshold flashes
  function automatic logic [3:0] dis_flash(input logic [6:0] soc);
    if (soc >= 7'd75) dis_flash = 4'hf;
    else if (soc >= 7'd50) dis_flash = 4'h7;
    else if (soc >= 7'd25) dis_flash = 4'h3;
    else dis_flash = 4'h1;
  endfunction

  // Fault class to flashing lamp set
  function automatic logic [3:0] flt_pat(input logic [3:0] cls);
    case (cls)
      4'h0: flt_pat = 4'h1;  // Cell voltage spread
      4'h1: flt_pat = 4'h2;  // Voltage
      4'h2: flt_pat = 4'h3;  // Temperature
      4'h3: flt_pat = 4'h4;  // Current
      4'h4: flt_pat = 4'h5;  // Hardware
      4'h5: flt_pat = 4'h6;  // Relay
      4'h6: flt_pat = 4'h7;  // Insulation
      4'h7: flt_pat = 4'h8;  // Self test
      4'h8: flt_pat = 4'h9;  // Inverter link lost
      4'h9: flt_pat = 4'ha;  // Module link lost
      default: flt_pat = 4'h0;
    endcase
  endfunction

  // 0.1 s tick prescaler
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 20'h0_0000;
    end else if (ce) begin
      if (pre_q == 20'(TICK_CYCLES - 1)) pre_q <= 20'h0_0000;
      else pre_q <= pre_q + 20'h0_0001;
    end
  end
  assign tick = ce && (pre_q == 20'(TICK_CYCLES - 1));

  // Pin synchronisers and tick-sampled debounce, press pulses
  genvar gi;
  generate
    for (gi = 0; gi < NBTN; gi++) begin : g_btn
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          samp_q[gi]  <= 1'b0;
          deb_q[gi]   <= 1'b0;
          press_q[gi] <= 1'b0;
        end else if (ce) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          press_q[gi] <= 1'b0;
          if (tick) begin
            samp_q[gi] <= sync2_q[gi];
            if (samp_q[gi] == sync2_q[gi] && deb_q[gi] != sync2_q[gi]) begin
              deb_q[gi]   <= sync2_q[gi];
              press_q[gi] <= sync2_q[gi];
            end
          end
        end
      end
    end
  endgenerate

  // Software registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 32'h0000_0000;
      soc_q  <= 7'h00;
      cfg_q  <= CFG_RESET;
      hour_q <= 5'h00;
      err_q  <= 8'h00;
    end else if (ce && bus_req.wr) begin
      if (bus_req.addr == OFS_CTRL) ctrl_q <= {1'b0, bus_req.wdata[30:0]};
      else if (bus_req.addr == OFS_SOC) soc_q <= bus_req.wdata[6:0];
      else if (bus_req.addr == OFS_CFG) cfg_q <= bus_req.wdata;
      else if (bus_req.addr == OFS_TIME) hour_q <= bus_req.wdata[4:0];
      else if (bus_req.addr == OFS_ERR) err_q <= bus_req.wdata[7:0];
    end
  end

  // Commit of staged settings, gated by the charge reserve margin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_q    <= CFG_RESET;
      cfg_valid_q <= 1'b0;
      reject_q    <= 1'b0;
    end else if (ce && bus_req.wr && bus_req.addr == OFS_COMMIT) begin
      if ({1'b0, soc_q} >= {1'b0, cfg_q[CFG_RES_LSB +: 7]} + RESERVE_MARGIN) begin
        active_q    <= cfg_q;
        cfg_valid_q <= 1'b1;
        reject_q    <= 1'b0;
      end else begin
        reject_q <= 1'b1;
      end
    end
  end

  // Charge window: start inclusive, end exclusive, may wrap midnight
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      charge_request <= 1'b0;
    end else if (ce) begin
      if (active_q[CFG_BEG_LSB +: 5] <= active_q[CFG_END_LSB +: 5])
        charge_request <= cfg_valid_q && hour_q >= active_q[CFG_BEG_LSB +: 5]
                          && hour_q < active_q[CFG_END_LSB +: 5];
      else
        charge_request <= cfg_valid_q && (hour_q >= active_q[CFG_BEG_LSB +: 5]
                          || hour_q < active_q[CFG_END_LSB +: 5]);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 32'h0000_0000;
    end else if (ce) begin
      bus_rdata <= 32'h0000_0000;
      if (bus_req.rd) begin
        if (bus_req.addr == OFS_CTRL) bus_rdata <= ctrl_q;
        else if (bus_req.addr == OFS_SOC) bus_rdata <= {25'h0, soc_q};
        else if (bus_req.addr == OFS_CFG) bus_rdata <= cfg_q;
        else if (bus_req.addr == OFS_TIME) bus_rdata <= {27'h0, hour_q};
        else if (bus_req.addr == OFS_ERR) bus_rdata <= {24'h0, err_q};
        else if (bus_req.addr == OFS_ACTIVE) bus_rdata <= active_q;
        else if (bus_req.addr == OFS_STATUS)
          bus_rdata <= {13'h0, value_q, reject_q, charge_request, menu_q, edit_q,
                        cursor_q, page_q, pack_q};
      end
    end
  end

  // Blink phase: 5 s frame in ticks
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 6'h00;
    end else if (ce) begin
      if (soft_clr) ph_q <= 6'h00;
      else if (tick) ph_q <= (ph_q == SLOW_PERIOD - 6'h01) ? 6'h00 : ph_q + 6'h01;
    end
  end
  assign fast_on = ph_q[0];                 // 0.1 s step
  assign half_on = (ph_q % 6'd10) < 6'd5;   // 0.5 s step
  assign slow_on = ph_q < SLOW_ON;          // 1 s on, 4 s off

  // Menu navigation and screen page
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_q   <= PAGE_POWER;
      menu_q   <= 1'b0;
      edit_q   <= 1'b0;
      cursor_q <= 2'h0;
      value_q  <= 8'h00;
    end else if (ce) begin
      if (soft_clr) begin
        page_q <= PAGE_POWER;
        menu_q <= 1'b0;
        edit_q <= 1'b0;
      end else if (inv_st == INV_FAULT) begin
        page_q <= PAGE_FAULT;
      end else begin
        if (page_q == PAGE_FAULT) page_q <= PAGE_POWER;
        if (press_q[1]) begin
          if (edit_q) edit_q <= 1'b0;
          else menu_q <= 1'b0;
        end else if (press_q[4]) begin
          if (!menu_q) menu_q <= 1'b1;
          else edit_q <= !edit_q;
        end else if (press_q[2]) begin
          if (edit_q) value_q <= value_q + 8'h01;
          else if (menu_q) cursor_q <= cursor_q - 2'h1;
          else page_q <= (page_q == PAGE_POWER) ? PAGE_BATTERY
                         : sic_page_t'(page_q - 2'h1);
        end else if (press_q[3]) begin
          if (edit_q) value_q <= value_q - 8'h01;
          else if (menu_q) cursor_q <= cursor_q + 2'h1;
          else page_q <= (page_q == PAGE_BATTERY) ? PAGE_POWER
                         : sic_page_t'(page_q + 2'h1);
        end
      end
    end
  end
  assign screen_page = page_q;

  // Error code beside the fault page, dropped with the page on clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) screen_error_code <= 8'h00;
    else if (ce) screen_error_code <= (inv_st == INV_FAULT && !soft_clr) ? err_q : 8'h00;
  end

  // Pack button hold counter in ticks, saturating
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 8'h00;
    end else if (ce) begin
      if (soft_clr || !deb_q[0]) hold_q <= 8'h00;
      else if (tick && hold_q != 8'hff) hold_q <= hold_q + 8'h01;
    end
  end

  // Pack state machine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pack_q         <= P_OFF;
      st_q           <= 8'h00;
      inverter_start <= 1'b0;
    end else if (ce) begin
      inverter_start <= 1'b0;
      if (tick && st_q != 8'hff) st_q <= st_q + 8'h01;
      if (soft_clr) begin
        pack_q <= P_OFF;
        st_q   <= 8'h00;
      end else begin
        case (pack_q)
          P_OFF: begin
            if (deb_q[0] && hold_q >= HOLD_BLACK_TICKS) begin
              pack_q <= P_BLACK;
            end else if (!deb_q[0] && hold_q >= HOLD_ON_TICKS) begin
              inverter_start <= hold_q >= HOLD_INV_TICKS;
              pack_q <= P_SELFTEST;
              st_q   <= 8'h00;
            end
          end
          P_BLACK: begin
            if (!deb_q[0]) begin
              pack_q <= P_SELFTEST;
              st_q   <= 8'h00;
            end
          end
          P_SELFTEST: begin
            if (st_q >= SELFTEST_TICKS) pack_q <= P_WAITCOMM;
          end
          P_WAITCOMM: begin
            if (ctrl_q[CTRL_COMM]) pack_q <= P_RUN;
            else if (deb_q[0] && hold_q >= HOLD_ON_TICKS) pack_q <= P_SHUTDOWN;
          end
          P_RUN: begin
            if (deb_q[0] && hold_q >= HOLD_ON_TICKS) pack_q <= P_SHUTDOWN;
          end
          default: begin
            if (!deb_q[0]) pack_q <= P_OFF;
          end
        endcase
      end
    end
  end

  // Fault solid-red timer and level-lamp chase step
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flt_q  <= 13'h0000;
      step_q <= 2'h0;
    end else if (ce) begin
      if (soft_clr || pack_q != P_RUN || run_md != RUN_FAULT) flt_q <= 13'h0000;
      else if (tick && flt_q != FAULT_SOLID) flt_q <= flt_q + 13'h0001;
      if (soft_clr) step_q <= 2'h0;
      else if (tick) step_q <= step_q + 2'h1;
    end
  end

  // Pack lamp pattern
  always_comb begin
    pack_d = '0;
    case (pack_q)
      P_BLACK: begin
        pack_d.stat_green = 1'b1;
        case (step_q)
          2'h0: pack_d.lvl_blue = 4'h4;
          2'h1: pack_d.lvl_blue = 4'ha;
          2'h2: pack_d.lvl_blue = 4'h1;
          default: pack_d.lvl_blue = 4'h0;
        endcase
      end
      P_SELFTEST: begin
        pack_d.stat_red   = fast_on;
        pack_d.stat_green = fast_on;
      end
      P_WAITCOMM: pack_d.stat_green = half_on;
      P_SHUTDOWN: begin
        pack_d.stat_green = 1'b1;
        pack_d.lvl_blue   = 4'h1 << step_q;
      end
      P_RUN: begin
        case (run_md)
          RUN_STANDBY: pack_d.stat_green = slow_on;
          RUN_CHARGE: begin
            pack_d.stat_green = 1'b1;
            pack_d.lvl_green  = chg_solid(soc_q)
              | ((half_on && soc_q < 7'd100) ? ((chg_solid(soc_q) << 1) | 4'h1) & ~chg_solid(soc_q)
                 : 4'h0);
          end
          RUN_DISCHARGE: begin
            pack_d.stat_green = 1'b1;
            pack_d.lvl_green  = half_on ? dis_flash(soc_q) : 4'h0;
          end
          RUN_FAULT: begin
            pack_d.stat_red  = (flt_q != FAULT_SOLID) || slow_on;
            pack_d.lvl_green = half_on ? flt_pat(ctrl_q[CTRL_FLT_LSB +: 4]) : 4'h0;
          end
          RUN_WARNING: begin
            pack_d.stat_red   = slow_on;
            pack_d.stat_green = slow_on;
          end
          default: begin
            pack_d.stat_green = 1'b1;
            pack_d.lvl_green  = chg_solid(soc_q) | ((soc_q < 7'd100) ? 4'h1 : 4'h0);
          end
        endcase
      end
      default: pack_d = '0;
    endcase
  end

  // Inverter panel lamp pattern
  always_comb begin
    inv_d            = '0;
    inv_d.run_blue   = (inv_st == INV_NORMAL) || (inv_st == INV_WAITING && half_on);
    inv_d.err_red    = (inv_st == INV_FAULT);
    inv_d.batt_green = (bat_st == BAT_NORMAL) || (bat_st == BAT_IDLE && half_on);
  end

  // Registered lamp outputs, dark on clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pack_lamps <= '0;
      inv_lamps  <= '0;
    end else if (ce) begin
      pack_lamps <= soft_clr ? '0 : pack_d;
      inv_lamps  <= soft_clr ? '0 : inv_d;
    end
  end
endmodule // sic_indicator

/* sic_indicator_chk.sv */
`timescale 1ns/1ns
module sic_indicator_chk (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic                     ce,
  input wire sic_pkg::sic_bus_req_t    bus_req,
  input wire logic [31:0]              bus_rdata,
  input wire sic_pkg::sic_inv_lamps_t  inv_lamps,
  input wire sic_pkg::sic_pack_lamps_t pack_lamps,
  input wire sic_pkg::sic_page_t       screen_page,
  input wire logic [7:0]               screen_error_code,
  input wire logic                     inverter_start
);
  import sic_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Bus events that the lamps and read data answer to
  sequence clear_wr;
    ce && bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[CTRL_CLEAR];
  endsequence
  sequence bad_rd;
    ce && bus_req.rd && bus_req.addr > OFS_STATUS;
  endsequence
  clear_dark_a: assert property (clear_wr |=> pack_lamps == '0)
    else $error("pack lamps lit after clear");
  rdata_idle_a: assert property ($past(ce) && bus_rdata != 32'h0 |-> $past(bus_req.rd))
    else $error("read data without a read");
  unmapped_zero_a: assert property (bad_rd |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  err_excl_a: assert property (inv_lamps.err_red |-> !inv_lamps.run_blue)
    else $error("blue and red lamps lit together");
  err_code_a: assert property (screen_error_code != 8'h0 |-> screen_page == PAGE_FAULT)
    else $error("error code off the fault page");
  fault_page_a: assert property (screen_page == PAGE_FAULT |-> inv_lamps.err_red)
    else $error("fault page without red lamp");
  start_pulse_a: assert property (inverter_start && ce |=> !inverter_start)
    else $error("start pulse too long");
  chase_green_a: assert property (pack_lamps.lvl_blue != 4'h0 |-> pack_lamps.stat_green && !pack_lamps.stat_red)
    else $error("blue chase without solid green");
  chase_order_a: assert property ($rose(pack_lamps.lvl_blue == 4'b1010) |-> $past(pack_lamps.lvl_blue) == 4'b0100)
    else $error("chase step out of order");
endmodule // sic_indicator_chk

bind sic_indicator sic_indicator_chk sic_indicator_chk_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .inv_lamps(inv_lamps), .pack_lamps(pack_lamps),
  .screen_page(screen_page), .screen_error_code(screen_error_code), .inverter_start(inverter_start));

/* sic_indicator_test.sv */
`timescale 1ns/1ns
module sic_indicator_test;
  import sic_pkg::*;
  localparam int TK = 10;
  logic            core_clk, rstn, ce, chg, istart;
  sic_bus_req_t    req;
  logic [31:0]     rdata, rv;
  logic [4:0]      keys;
  logic [7:0]      ecode, v0;
  logic [1:0]      c0;
  sic_inv_lamps_t  inv;
  sic_pack_lamps_t pack;
  sic_page_t       page;
  logic [13:0]     vec, hi, lo;
  int              bad_count, checks, cnt;
  assign vec = {istart, inv, pack};
  sic_indicator #(.TICK_CYCLES(TK)) sic_indicator_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .bus_req(req), .bus_rdata(rdata), .pack_power_button(keys[0]), .key_esc(keys[1]), .key_up(keys[2]),
    .key_down(keys[3]), .key_enter(keys[4]), .inv_lamps(inv), .pack_lamps(pack), .screen_page(page),
    .screen_error_code(ecode), .charge_request(chg), .inverter_start(istart));
  sic_operator #(.TK(TK)) sic_operator_i (.core_clk(core_clk), .keys(keys));
  // System clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req <= '0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    req <= '0;
    @(negedge core_clk);
    rv = rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge core_clk);
  endtask
  // Lamps over n ticks: any-on, always-on, samples matching mask m
  task automatic obs(input int n, input logic [13:0] m);
    @(posedge core_clk);  // Let the registered lamps take the new state
    hi = '0;
    lo = '1;
    cnt = 0;
    repeat (n * TK) begin
      @(negedge core_clk);
      hi |= vec;
      lo &= vec;
      if ((vec & m) == m) cnt++;
    end
  endtask
  task automatic key(input int k);
    sic_operator_i.press(k, 4);
    ticks(4);
    rd(OFS_STATUS);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    req = '0;
    ce = 1'b1;
    rstn = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({inv, pack, page, ecode, chg, istart}, 32'h0);
    for (int i = 1; i <= 3; i++) begin
      key(2);
      chk(page, (3 - i) % 3);
    end
    key(3);
    chk(page, PAGE_YIELD);
    key(4);
    chk(rv[8:7], 2'b10);
    c0 = rv[6:5];
    key(2);
    chk(rv[6:5] != c0, 1'b1);
    key(3);
    chk(rv[6:5], c0);
    key(4);
    chk(rv[8:7], 2'b11);
    v0 = rv[18:11];
    key(2);
    chk(rv[18:11], v0 + 8'h1);
    key(3);
    chk(rv[18:11], v0);
    key(1);
    chk(rv[8:7], 2'b10);
    key(1);
    chk(rv[8:7], 2'b00);
    wr(OFS_ERR, 32'h5a);
    wr(OFS_CTRL, 32'h0);
    obs(30, '0);
    chk({hi[12:10], lo[12:10], ecode}, {6'b101101, 8'h0});
    wr(OFS_CTRL, 32'h5);
    obs(30, '0);
    chk({hi[12], lo[12], hi[10], lo[10]}, 4'b1010);
    wr(OFS_CTRL, 32'ha);
    obs(30, '0);
    chk({hi[12:10], lo[12:10], page, ecode}, {6'b010010, PAGE_FAULT, 8'h5a});
    // A write while the clock enable is low must be refused
    @(posedge core_clk);
    ce <= 1'b0;
    wr(OFS_ERR, 32'h33);
    ce <= 1'b1;
    rd(OFS_ERR);
    chk(rv, 32'h5a);
    wr(OFS_SOC, 32'h32);
    wr(OFS_CFG, 32'h310c5);
    wr(OFS_COMMIT, 32'h1);
    rd(OFS_STATUS);
    chk(rv[10], 1'b1);
    rd(OFS_ACTIVE);
    chk(rv, CFG_RESET);
    wr(OFS_CFG, 32'h310c1);
    wr(OFS_COMMIT, 32'h1);
    rd(OFS_ACTIVE);
    chk(rv, 32'h310c1);
    rd(8'h20);
    chk(rv, 32'h0);
    for (int h = 7; h <= 12; h++) begin
      wr(OFS_TIME, h);
      ticks(1);
      chk(chg, h >= 8 && h < 12);
    end
    wr(OFS_CTRL, 32'h0);
    sic_operator_i.press(0, 12);
    ticks(4);
    rd(OFS_STATUS);
    chk(rv[2:0], 3'h2);
    obs(20, '0);
    chk({hi[9:0], lo[9:8]}, {2'b11, 8'h0, 2'b00});
    ticks(20);
    rd(OFS_STATUS);
    chk(rv[2:0], 3'h3);
    obs(20, '0);
    chk({hi[9:0], lo[9:8]}, {2'b01, 8'h0, 2'b00});
    wr(OFS_CTRL, 32'h90);
    rd(OFS_STATUS);
    chk(rv[2:0], 3'h4);
    obs(20, '0);
    chk({hi[9:4], lo[9:4]}, {6'b010111, 6'b010011});
    wr(OFS_SOC, 32'h64);
    obs(10, '0);
    chk(lo[7:4], 4'hf);
    wr(OFS_SOC, 32'h32);
    wr(OFS_CTRL, 32'ha0);
    obs(20, '0);
    chk({hi[9:4], lo[9:4]}, {6'b010111, 6'b010000});
    wr(OFS_CTRL, 32'h80);
    obs(50, 14'h100);
    chk({cnt[15:0], hi[9:0]}, {16'(10 * TK), 10'h100});
    wr(OFS_CTRL, 32'hc0);
    obs(50, 14'h300);
    chk(cnt, 10 * TK);
    for (int c = 0; c < 10; c++) begin
      wr(OFS_CTRL, 32'hb0 | (c << 8));
      obs(12, '0);
      chk({hi[7:4] | hi[3:0], lo[7:0], lo[9], hi[8]}, {4'(c + 1), 8'h0, 2'b10});
    end
    wr(OFS_CTRL, 32'h90);
    fork
      sic_operator_i.press(0, 18);
      begin ticks(14); obs(3, '0); end
    join
    chk({|hi[3:0], lo[9:8]}, 3'b101);
    ticks(24);
    chk(pack, 10'h0);
    fork
      sic_operator_i.press(0, 60);
      obs(66, 14'h2000);
    join
    chk(cnt, 1);
    wr(OFS_CTRL, 32'h8000_0000);
    rd(OFS_STATUS);
    chk({rv[2:0], pack}, 13'h0);
    fork
      sic_operator_i.press(0, 210);
      begin ticks(203); obs(6, '0); end
    join
    chk({hi[3:0], lo[8]}, 5'b11111);
    ticks(6);
    rd(OFS_STATUS);
    chk(rv[2:0], 3'h2);
    print_verdict();
  end
endmodule // sic_indicator_test

/* sic_operator.sv */
`timescale 1ns/1ns
module sic_operator #(
  parameter int TK = 10
) (
  input  wire logic       core_clk,
  output logic      [4:0] keys
);
  // Nothing pressed at power-up
  initial keys = 5'h0;
  // Hold one key for n ticks, then let go; one key at a time
  task automatic press(input int k, input int n);
    @(posedge core_clk);
    keys[k] <= 1'b1;
    repeat (n * TK) @(posedge core_clk);
    keys[k] <= 1'b0;
  endtask
endmodule // sic_operator

/* sic_pkg.sv */
package sic_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 100_000_000;   // 0.1 s lamp/hold step
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  // Durations in 0.1 s ticks; charge margin in percent
  localparam logic [7:0]  HOLD_ON_TICKS    = 8'h0a;     // 1 s activation/shutdown hold
  localparam logic [7:0]  HOLD_INV_TICKS   = 8'h32;     // 5 s inverter startup hold
  localparam logic [7:0]  HOLD_BLACK_TICKS = 8'hc8;     // 20 s black-start hold
  localparam logic [7:0]  SELFTEST_TICKS   = 8'h23;     // 3.5 s self test
  localparam logic [5:0]  SLOW_PERIOD      = 6'h32;     // 5 s slow pattern period
  localparam logic [5:0]  SLOW_ON          = 6'h0a;     // 1 s on phase
  localparam logic [12:0] FAULT_SOLID      = 13'h1770;  // 10 min solid red
  localparam logic [7:0]  RESERVE_MARGIN   = 8'h02;     // 2 % charge margin
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SOC    = 8'h04;
  localparam logic [7:0] OFS_CFG    = 8'h08;
  localparam logic [7:0] OFS_COMMIT = 8'h0c;
  localparam logic [7:0] OFS_TIME   = 8'h10;
  localparam logic [7:0] OFS_ERR    = 8'h14;
  localparam logic [7:0] OFS_ACTIVE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Control register fields
  localparam int CTRL_INV_LSB = 0;   // [1:0] inverter state
  localparam int CTRL_BAT_LSB = 2;   // [3:2] battery link state
  localparam int CTRL_RUN_LSB = 4;   // [6:4] pack run mode
  localparam int CTRL_COMM    = 7;   // inverter link up
  localparam int CTRL_FLT_LSB = 8;   // [11:8] fault class
  localparam int CTRL_CLEAR   = 31;  // write 1: synchronous clear
  // Config register fields
  localparam int CFG_MODE_LSB = 0;   // [1:0]
  localparam int CFG_RES_LSB  = 2;   // [8:2]
  localparam int CFG_BEG_LSB  = 9;   // [13:9]
  localparam int CFG_END_LSB  = 14;  // [18:14]
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {INV_NORMAL, INV_WAITING, INV_FAULT} sic_inv_state_t;
  typedef enum logic [1:0] {BAT_NORMAL, BAT_IDLE, BAT_FAULT} sic_bat_state_t;
  typedef enum logic [2:0] {RUN_STANDBY, RUN_CHARGE, RUN_DISCHARGE, RUN_FAULT, RUN_WARNING} sic_run_mode_t;
  typedef enum logic [1:0] {PAGE_POWER, PAGE_YIELD, PAGE_BATTERY, PAGE_FAULT} sic_page_t;

  // Register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sic_bus_req_t;

  // Inverter panel lamps
  typedef struct packed {
    logic run_blue;
    logic err_red;
    logic batt_green;
  } sic_inv_lamps_t;

  // Battery unit lamps; lamp 1 is bit 0
  typedef struct packed {
    logic       stat_red;
    logic       stat_green;
    logic [3:0] lvl_green;
    logic [3:0] lvl_blue;
  } sic_pack_lamps_t;
endpackage
